// >>> bcc_pkg.sv
// package: register map, field layout, reset values and timing for the clock config block
package bcc_pkg;
	localparam logic [15:0] ADDR_SRC_SEL = 16'hdf16;
	localparam logic [15:0] ADDR_FPGA_RST = 16'hdf22;
	localparam logic [15:0] ADDR_STEP = 16'hdf23;
	localparam logic [15:0] ADDR_NET0_MUL = 16'hdf30;
	localparam logic [15:0] ADDR_NET1_DIV = 16'hdf31;
	localparam logic [15:0] ADDR_NET1_MUL = 16'hdf32;
	localparam logic [15:0] ADDR_NET2_DIV = 16'hdf33;
	localparam logic [15:0] ADDR_NET2_MUL = 16'hdf34;
	localparam logic [15:0] ADDR_BUS_DIS = 16'hdf39;
	localparam logic [15:0] ADDR_UPDATE = 16'hdf40;
	localparam logic [15:0] ADDR_TEMP_A = 16'hdf50;
	localparam logic [15:0] ADDR_TEMP_B = 16'hdf51;
	localparam logic [15:0] ADDR_NET0_DIV = 16'hdfc0;
	localparam logic [15:0] ADDR_SERIAL = 16'hdffa;
	localparam logic [15:0] ADDR_KIND = 16'hdffe;
	// field layout
	localparam int NET0 = 0;
	localparam int NET1 = 1;
	localparam int NET2 = 2;
	localparam int NUM_NETS = 3;
	localparam int STEP0_BIT = 0;
	localparam int STEP1_BIT = 1;
	localparam logic [7:0] RST_HOLD = 8'h02;
	localparam logic [7:0] RST_RELEASE = 8'h00;
	localparam logic [7:0] SRC_MASK = 8'h07;
	localparam logic [7:0] UPD_MASK = 8'h07;
	localparam logic [7:0] STEP_MASK = 8'h03;
	// reset values
	localparam logic [7:0] SRC_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET = 8'h01;
	localparam logic [7:0] MUL_RESET = 8'h01;
	localparam logic [7:0] ZERO8 = 8'h00;
	// frequency step of the synthesizer path, in kHz, and ceiling in kHz
	localparam int FREQ_STEP_KHZ = 125;
	localparam int FREQ_MAX_KHZ = 550000;
	// time a network is held disturbed while it is reprogrammed
	localparam int CLK_MHZ = 100;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] SETTLE_COUNT = 8'(SETTLE_CYCLES);
	typedef enum logic [2:0] {
		BCC_IDLE = 3'b001,
		BCC_LOAD = 3'b010,
		BCC_WAIT = 3'b100
	} bcc_upd_state_t;
endpackage

// >>> bcc_net_update.sv
// per-network reprogramming sequencer: latches source and ratio, then settles
`timescale 1ns/1ps
module bcc_net_update (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic src_alt,
	input wire logic [7:0] mul,
	input wire logic [7:0] div,
	output logic busy,
	output logic done,
	output logic applied_alt,
	output logic [7:0] applied_mul,
	output logic [7:0] applied_div
);
	typedef struct packed {
		bcc_pkg::bcc_upd_state_t st;
		logic [7:0] cnt;
		logic done;
		logic alt;
		logic [7:0] mul;
		logic [7:0] div;
	} bcc_upd_t;
	bcc_upd_t cur;
	bcc_upd_t next_cur;

	// sequencer next state
	always_comb begin
		next_cur = cur;
		next_cur.done = 1'b0;
		case (cur.st)
			bcc_pkg::BCC_IDLE: begin
				if (start) begin
					next_cur.st = bcc_pkg::BCC_LOAD;
				end
			end
			bcc_pkg::BCC_LOAD: begin
				// take current values at update time
				next_cur.alt = src_alt;
				next_cur.mul = mul;
				next_cur.div = div;
				next_cur.cnt = bcc_pkg::SETTLE_COUNT;
				next_cur.st = bcc_pkg::BCC_WAIT;
			end
			bcc_pkg::BCC_WAIT: begin
				// network disturbed until count ends
				if (cur.cnt == bcc_pkg::ZERO8 + 8'h01) begin
					next_cur.done = 1'b1;
					next_cur.st = bcc_pkg::BCC_IDLE;
				end
				next_cur.cnt = cur.cnt - 8'h01;
			end
			default: begin
				next_cur.st = bcc_pkg::BCC_IDLE;
			end
		endcase
	end

	// state register; synthesizer is the source after reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur <= '{st: bcc_pkg::BCC_IDLE, cnt: bcc_pkg::ZERO8, done: 1'b0, alt: 1'b0,
				mul: bcc_pkg::MUL_RESET, div: bcc_pkg::DIV_RESET};
		end else begin
			cur <= next_cur;
		end
	end

	assign busy = (cur.st != bcc_pkg::BCC_IDLE);
	assign done = cur.done;
	assign applied_alt = cur.alt;
	assign applied_mul = cur.mul;
	assign applied_div = cur.div;

	a_load_takes_values: assert property (@(posedge sys_clk) disable iff (rst)
		cur.st == bcc_pkg::BCC_LOAD |=> (cur.alt == $past(src_alt)) && (cur.mul == $past(mul)))
		else $error("update did not latch current values");
	a_settle_bounded: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(cur.st == bcc_pkg::BCC_WAIT) |-> ##[1:120] done)
		else $error("settle period did not end");
endmodule // bcc_net_update

// >>> bcc_clock_regs.sv
// top: byte-addressed clock configuration register space with source muxing
`timescale 1ns/1ps
module bcc_clock_regs (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] temperature_fpga_a,
	input wire logic [7:0] temperature_fpga_b,
	input wire logic [7:0] serial_in,
	input wire logic [7:0] kind_in,
	input wire logic synth_clk0,
	input wire logic synth_clk1,
	input wire logic synth_clk2,
	input wire logic fpga_a_feedback_clock,
	output logic primary_net_zero,
	output logic primary_net_one,
	output logic primary_net_two,
	output logic [7:0] synth_mul0,
	output logic [7:0] synth_div0,
	output logic [7:0] synth_mul1,
	output logic [7:0] synth_div1,
	output logic [7:0] synth_mul2,
	output logic [7:0] synth_div2,
	output logic [2:0] net_disturbed,
	output logic user_fpga_reset,
	output logic main_bus_disabled
);
	typedef struct packed {
		logic [7:0] src_sel;
		logic [7:0] rst_ctrl;
		logic [7:0] step;
		logic [7:0] mul0;
		logic [7:0] div0;
		logic [7:0] mul1;
		logic [7:0] div1;
		logic [7:0] mul2;
		logic [7:0] div2;
		logic [7:0] bus_dis;
		logic [7:0] upd;
		logic [7:0] rdata;
		logic [2:0] nets;
		logic [2:0] disturbed;
		logic fpga_rst;
		logic bus_off;
	} bcc_regs_t;
	bcc_regs_t cur;
	bcc_regs_t next_cur;

	logic [2:0] seq_busy;
	logic [2:0] seq_done;
	logic [2:0] seq_alt;
	logic [7:0] seq_mul [3];
	logic [7:0] seq_div [3];
	logic [7:0] cfg_mul [3];
	logic [7:0] cfg_div [3];
	logic [2:0] upd_start;

	assign cfg_mul[0] = cur.mul0;
	assign cfg_mul[1] = cur.mul1;
	assign cfg_mul[2] = cur.mul2;
	assign cfg_div[0] = cur.div0;
	assign cfg_div[1] = cur.div1;
	assign cfg_div[2] = cur.div2;
	// update request launches a network sequencer
	assign upd_start = reg_wr && (reg_addr == bcc_pkg::ADDR_UPDATE) ?
		(reg_wdata[2:0] & bcc_pkg::UPD_MASK[2:0]) : 3'h0;

	// one sequencer per network
	genvar gi;
	generate
		for (gi = 0; gi < bcc_pkg::NUM_NETS; gi++) begin : g_net
			bcc_net_update u_upd (
				.sys_clk(sys_clk),
				.rst(rst),
				.start(upd_start[gi] && !seq_busy[gi]),
				.src_alt(cur.src_sel[gi]),
				.mul(cfg_mul[gi]),
				.div(cfg_div[gi]),
				.busy(seq_busy[gi]),
				.done(seq_done[gi]),
				.applied_alt(seq_alt[gi]),
				.applied_mul(seq_mul[gi]),
				.applied_div(seq_div[gi])
			);
		end
	endgenerate

	// register writes, read mux and clock source muxing
	always_comb begin
		next_cur = cur;
		// read data, address decode
		if (reg_rd) begin
			if (reg_addr == bcc_pkg::ADDR_SRC_SEL) begin
				next_cur.rdata = cur.src_sel;
			end else if (reg_addr == bcc_pkg::ADDR_FPGA_RST) begin
				next_cur.rdata = cur.rst_ctrl;
			end else if (reg_addr == bcc_pkg::ADDR_STEP) begin
				next_cur.rdata = cur.step;
			end else if (reg_addr == bcc_pkg::ADDR_NET0_MUL) begin
				next_cur.rdata = cur.mul0;
			end else if (reg_addr == bcc_pkg::ADDR_NET0_DIV) begin
				next_cur.rdata = cur.div0;
			end else if (reg_addr == bcc_pkg::ADDR_NET1_DIV) begin
				next_cur.rdata = cur.div1;
			end else if (reg_addr == bcc_pkg::ADDR_NET1_MUL) begin
				next_cur.rdata = cur.mul1;
			end else if (reg_addr == bcc_pkg::ADDR_NET2_DIV) begin
				next_cur.rdata = cur.div2;
			end else if (reg_addr == bcc_pkg::ADDR_NET2_MUL) begin
				next_cur.rdata = cur.mul2;
			end else if (reg_addr == bcc_pkg::ADDR_BUS_DIS) begin
				next_cur.rdata = cur.bus_dis;
			end else if (reg_addr == bcc_pkg::ADDR_UPDATE) begin
				next_cur.rdata = cur.upd;
			end else if (reg_addr == bcc_pkg::ADDR_TEMP_A) begin
				next_cur.rdata = temperature_fpga_a;
			end else if (reg_addr == bcc_pkg::ADDR_TEMP_B) begin
				next_cur.rdata = temperature_fpga_b;
			end else if (reg_addr == bcc_pkg::ADDR_SERIAL) begin
				next_cur.rdata = serial_in;
			end else if (reg_addr == bcc_pkg::ADDR_KIND) begin
				next_cur.rdata = kind_in;
			end else begin
				next_cur.rdata = bcc_pkg::ZERO8;
			end
		end
		// completed updates clear their flag first, so a new write still sets it
		next_cur.upd = cur.upd & ~{5'h00, seq_done};
		// writes, read-only addresses ignored
		if (reg_wr) begin
			if (reg_addr == bcc_pkg::ADDR_SRC_SEL) begin
				next_cur.src_sel = reg_wdata & bcc_pkg::SRC_MASK;
			end else if (reg_addr == bcc_pkg::ADDR_FPGA_RST) begin
				next_cur.rst_ctrl = reg_wdata;
				if (reg_wdata == bcc_pkg::RST_HOLD) begin
					next_cur.fpga_rst = 1'b1;
				end else if (reg_wdata == bcc_pkg::RST_RELEASE) begin
					next_cur.fpga_rst = 1'b0;
				end
			end else if (reg_addr == bcc_pkg::ADDR_STEP) begin
				next_cur.step = reg_wdata & bcc_pkg::STEP_MASK;
			end else if (reg_addr == bcc_pkg::ADDR_NET0_MUL) begin
				next_cur.mul0 = reg_wdata;
			end else if (reg_addr == bcc_pkg::ADDR_NET0_DIV) begin
				next_cur.div0 = reg_wdata;
			end else if (reg_addr == bcc_pkg::ADDR_NET1_DIV) begin
				next_cur.div1 = reg_wdata;
			end else if (reg_addr == bcc_pkg::ADDR_NET1_MUL) begin
				next_cur.mul1 = reg_wdata;
			end else if (reg_addr == bcc_pkg::ADDR_NET2_DIV) begin
				next_cur.div2 = reg_wdata;
			end else if (reg_addr == bcc_pkg::ADDR_NET2_MUL) begin
				next_cur.mul2 = reg_wdata;
			end else if (reg_addr == bcc_pkg::ADDR_BUS_DIS) begin
				next_cur.bus_dis = reg_wdata;
				next_cur.bus_off = 1'b1;
			end else if (reg_addr == bcc_pkg::ADDR_UPDATE) begin
				next_cur.upd = next_cur.upd | (reg_wdata & bcc_pkg::UPD_MASK);
			end
		end
		// each network takes the source latched by its last update
		next_cur.nets[bcc_pkg::NET0] = seq_alt[0] ? cur.step[bcc_pkg::STEP0_BIT] : synth_clk0;
		next_cur.nets[bcc_pkg::NET1] = seq_alt[1] ? cur.step[bcc_pkg::STEP1_BIT] : synth_clk1;
		next_cur.nets[bcc_pkg::NET2] = seq_alt[2] ? fpga_a_feedback_clock : synth_clk2;
		next_cur.disturbed = seq_busy | upd_start;
	end

	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur <= '{src_sel: bcc_pkg::SRC_RESET, rst_ctrl: bcc_pkg::ZERO8, step: bcc_pkg::ZERO8,
				mul0: bcc_pkg::MUL_RESET, div0: bcc_pkg::DIV_RESET, mul1: bcc_pkg::MUL_RESET,
				div1: bcc_pkg::DIV_RESET, mul2: bcc_pkg::MUL_RESET, div2: bcc_pkg::DIV_RESET,
				bus_dis: bcc_pkg::ZERO8, upd: bcc_pkg::ZERO8, rdata: bcc_pkg::ZERO8,
				nets: 3'h0, disturbed: 3'h0, fpga_rst: 1'b0, bus_off: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata = cur.rdata;
	assign primary_net_zero = cur.nets[bcc_pkg::NET0];
	assign primary_net_one = cur.nets[bcc_pkg::NET1];
	assign primary_net_two = cur.nets[bcc_pkg::NET2];
	// applied ratio; 8-bit fields bound the reachable steps
	assign synth_mul0 = seq_mul[0];
	assign synth_div0 = seq_div[0];
	assign synth_mul1 = seq_mul[1];
	assign synth_div1 = seq_div[1];
	assign synth_mul2 = seq_mul[2];
	assign synth_div2 = seq_div[2];
	assign net_disturbed = cur.disturbed;
	assign user_fpga_reset = cur.fpga_rst;
	assign main_bus_disabled = cur.bus_off;

	// register storage checks
	a_src_write: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_SRC_SEL |=> cur.src_sel == ($past(reg_wdata) & 8'h07))
		else $error("source select not stored");
	a_reset_hold: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_FPGA_RST && reg_wdata == 8'h02 |=> user_fpga_reset)
		else $error("fpga reset not held");
	a_reset_release: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_FPGA_RST && reg_wdata == 8'h00 |=> !user_fpga_reset)
		else $error("fpga reset not released");
	a_net0_ratio: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_NET0_DIV |=> cur.div0 == $past(reg_wdata))
		else $error("network zero divider not stored");
	a_net0_mul_store: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_NET0_MUL |=> cur.mul0 == $past(reg_wdata))
		else $error("network zero multiplier not stored");
	a_net1_ratio: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_NET1_MUL |=> cur.mul1 == $past(reg_wdata))
		else $error("network one multiplier not stored");
	a_net1_div_store: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_NET1_DIV |=> cur.div1 == $past(reg_wdata))
		else $error("network one divider not stored");
	a_net2_mul_store: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_NET2_MUL |=> cur.mul2 == $past(reg_wdata))
		else $error("network two multiplier not stored");
	a_net2_div_store: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_NET2_DIV |=> cur.div2 == $past(reg_wdata))
		else $error("network two divider not stored");
	a_step_write: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_STEP |=> cur.step == ($past(reg_wdata) & 8'h03))
		else $error("step register not stored");
	a_bus_disable: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_BUS_DIS |=> main_bus_disabled)
		else $error("main bus not disabled");
	a_bus_sticky: assert property (@(posedge sys_clk) disable iff (rst)
		main_bus_disabled |=> main_bus_disabled)
		else $error("main bus disable dropped before reset");

	// read path checks
	a_temp_read: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == bcc_pkg::ADDR_TEMP_A |=> reg_rdata == $past(temperature_fpga_a))
		else $error("temperature A misread");
	a_temp_b_read: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == bcc_pkg::ADDR_TEMP_B |=> reg_rdata == $past(temperature_fpga_b))
		else $error("temperature B misread");
	a_rdata_holds: assert property (@(posedge sys_clk) disable iff (rst)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	// network source checks
	a_alt_net2: assert property (@(posedge sys_clk) disable iff (rst)
		seq_alt[2] |=> primary_net_two == $past(fpga_a_feedback_clock))
		else $error("network two not on feedback clock");
	a_alt_net1: assert property (@(posedge sys_clk) disable iff (rst)
		seq_alt[1] |=> primary_net_one == $past(cur.step[1]))
		else $error("step clock one not driving network");
	a_step_drive: assert property (@(posedge sys_clk) disable iff (rst)
		seq_alt[0] |=> primary_net_zero == $past(cur.step[0]))
		else $error("step clock zero not driving network");
	a_synth_default: assert property (@(posedge sys_clk) disable iff (rst)
		!seq_alt[0] |=> primary_net_zero == $past(synth_clk0))
		else $error("network zero not on synthesizer");

	// update sequencing checks
	a_update_sets: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == bcc_pkg::ADDR_UPDATE && reg_wdata[0] |=> cur.upd[0])
		else $error("update flag not set by write");
	a_update_applies: assert property (@(posedge sys_clk) disable iff (rst)
		upd_start[0] && !seq_busy[0] |=> ##1 ##1 synth_mul0 == $past(cur.mul0, 2))
		else $error("network zero ratio not applied");
	a_update_clears: assert property (@(posedge sys_clk) disable iff (rst)
		seq_done[1] && !(reg_wr && reg_addr == bcc_pkg::ADDR_UPDATE) |=> !cur.upd[1])
		else $error("update flag did not self-clear");
	a_busy_flag: assert property (@(posedge sys_clk) disable iff (rst)
		seq_busy[2] |=> net_disturbed[2])
		else $error("disturbed flag missing during update");
	a_disturb_start: assert property (@(posedge sys_clk) disable iff (rst)
		upd_start[1] |=> net_disturbed[1])
		else $error("disturbed flag late at update start");

	// main scenarios
	c_switch_src: cover property (@(posedge sys_clk) disable iff (rst) seq_done[0] && seq_alt[0]);
	c_reset_held: cover property (@(posedge sys_clk) disable iff (rst) $rose(user_fpga_reset));
	c_bus_off: cover property (@(posedge sys_clk) disable iff (rst) $rose(main_bus_disabled));
	c_net2_feedback: cover property (@(posedge sys_clk) disable iff (rst) seq_done[2] && seq_alt[2]);
	c_step_toggle: cover property (@(posedge sys_clk) disable iff (rst) seq_alt[1] && $rose(primary_net_one));
endmodule // bcc_clock_regs

// >>> bcc_far_model.sv
// far-side model: synthesizer outputs, fpga A feedback clock and board sensor levels
`timescale 1ns/1ps
module bcc_far_model (
	input wire logic sys_clk,
	input wire logic [7:0] temp_level,
	output logic synth_clk0,
	output logic synth_clk1,
	output logic synth_clk2,
	output logic fpga_a_feedback_clock,
	output logic [7:0] temp_a,
	output logic [7:0] temp_b,
	output logic [7:0] serial_val,
	output logic [7:0] kind_val
);
	logic [3:0] cnt = 4'h0;
	// free-running clocks, moved away from the sampling edge so they are never raced
	always @(negedge sys_clk) begin
		cnt <= cnt + 4'h1;
	end
	assign synth_clk0 = cnt[0];
	assign synth_clk1 = cnt[1];
	assign synth_clk2 = cnt[2];
	assign fpga_a_feedback_clock = cnt[2] ^ cnt[0];
	// sensor A follows the level the bench sets, sensor B its inverse
	assign temp_a = temp_level;
	assign temp_b = ~temp_level;
	// board id levels, fixed
	initial begin
		serial_val = 8'h5c; // arbitrary value
		kind_val = 8'h17; // arbitrary value
	end
endmodule // bcc_far_model

// >>> board_clock_config_registers_tb.sv
// self-checking bench for the clock configuration register block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("unexpected %0t: got %h want %h", $time, a, b); end end
module board_clock_config_registers_tb;
	localparam logic [15:0] DIV_A[3] = '{bcc_pkg::ADDR_NET0_DIV, bcc_pkg::ADDR_NET1_DIV, bcc_pkg::ADDR_NET2_DIV};
	localparam logic [15:0] MUL_A[3] = '{bcc_pkg::ADDR_NET0_MUL, bcc_pkg::ADDR_NET1_MUL, bcc_pkg::ADDR_NET2_MUL};
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic s0, s1, s2, fb, primary_net_zero, primary_net_one, primary_net_two, user_fpga_reset, main_bus_disabled;
	logic [7:0] ta, tb, sn, kd;
	logic [7:0] temp_level = 8'h2a;
	logic [7:0] mul_o[3];
	logic [7:0] div_o[3];
	logic [2:0] net_disturbed;
	int errors = 0;
	int compares = 0;
	logic [7:0] exp_q[$];
	logic [7:0] exp_v;
	logic rd_seen = 1'b0;
	logic [3:0] src_q;
	logic [1:0] step_v = 2'b00;
	logic [7:0] src_v = 8'h00;
	logic [7:0] mul_v[3] = '{8'h01, 8'h01, 8'h01};
	logic [7:0] div_v[3] = '{8'h01, 8'h01, 8'h01};
	always #5 sys_clk = ~sys_clk;
	bcc_far_model i_far (.sys_clk(sys_clk), .temp_level(temp_level), .synth_clk0(s0), .synth_clk1(s1), .synth_clk2(s2),
		.fpga_a_feedback_clock(fb), .temp_a(ta), .temp_b(tb), .serial_val(sn), .kind_val(kd));
	bcc_clock_regs i_dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .temperature_fpga_a(ta), .temperature_fpga_b(tb),
		.serial_in(sn), .kind_in(kd), .synth_clk0(s0), .synth_clk1(s1), .synth_clk2(s2),
		.fpga_a_feedback_clock(fb), .primary_net_zero(primary_net_zero), .primary_net_one(primary_net_one),
		.primary_net_two(primary_net_two), .synth_mul0(mul_o[0]), .synth_div0(div_o[0]),
		.synth_mul1(mul_o[1]), .synth_div1(div_o[1]), .synth_mul2(mul_o[2]), .synth_div2(div_o[2]),
		.net_disturbed(net_disturbed), .user_fpga_reset(user_fpga_reset), .main_bus_disabled(main_bus_disabled));
	// sources as the design sampled them
	always @(posedge sys_clk) begin
		src_q <= {fb, s2, s1, s0};
		rd_seen <= reg_rd;
	end
	// read watcher: oldest expected value against the registered read data
	always @(negedge sys_clk) begin
		if (rd_seen && exp_q.size() > 0) begin
			exp_v = exp_q.pop_front();
			`CHK(reg_rdata, exp_v)
		end
	end
	task automatic report_and_stop();
		if (errors == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// one byte write, then one settle cycle
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		@(negedge sys_clk);
	endtask
	// one byte read; the watcher checks the answer
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		exp_q.push_back(e);
		@(negedge sys_clk);
		reg_rd = 1'b0;
	endtask
	// network outputs against selected source, one cycle behind
	task automatic check_nets(input logic [2:0] alt);
		repeat (6) begin
			@(negedge sys_clk);
			`CHK(primary_net_zero, alt[0] ? step_v[0] : src_q[0])
			`CHK(primary_net_one, alt[1] ? step_v[1] : src_q[1])
			`CHK(primary_net_two, alt[2] ? src_q[3] : src_q[2])
		end
	endtask
	// program one network's ratio and source, then trigger its update
	task automatic upd(input int n, input logic [7:0] d, input logic [7:0] m);
		int k;
		wr(DIV_A[n], d);
		wr(MUL_A[n], m);
		rd(DIV_A[n], d);
		rd(MUL_A[n], m);
		`CHK(mul_o[n], mul_v[n])
		src_v[n] = 1'b1;
		wr(bcc_pkg::ADDR_SRC_SEL, src_v);
		wr(bcc_pkg::ADDR_UPDATE, 8'h01 << n);
		`CHK(net_disturbed[n], 1'b1)
		rd(bcc_pkg::ADDR_UPDATE, 8'h01 << n);
		k = 0;
		while (net_disturbed[n] !== 1'b0 && k < 400) begin
			@(negedge sys_clk);
			k++;
		end
		if (k == 400) begin
			errors++;
			$display("unexpected %0t: update never finished", $time);
			report_and_stop();
		end
		mul_v[n] = m;
		div_v[n] = d;
		`CHK(mul_o[n], m)
		`CHK(div_o[n], d)
		rd(bcc_pkg::ADDR_UPDATE, 8'h00);
	endtask
	initial begin
		#900000;
		errors++;
		$display("unexpected %0t: run timed out", $time);
		report_and_stop();
	end
	initial begin
		logic [7:0] d;
		void'($urandom(32'h3544));
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		for (int i = 0; i < 3; i++) `CHK(mul_o[i], 8'h01)
		check_nets(3'b000);
		for (int n = 0; n < 3; n++) begin
			upd(n, 8'hff, 8'h01);
			upd(n, 8'($urandom_range(255, 1)), 8'($urandom_range(255, 1)));
		end
		rd(bcc_pkg::ADDR_SRC_SEL, 8'h07);
		step_v = 2'b01;
		wr(bcc_pkg::ADDR_STEP, 8'h01);
		check_nets(3'b111);
		step_v = 2'b10;
		wr(bcc_pkg::ADDR_STEP, 8'h02);
		check_nets(3'b111);
		wr(bcc_pkg::ADDR_FPGA_RST, 8'h02);
		`CHK(user_fpga_reset, 1'b1)
		wr(bcc_pkg::ADDR_FPGA_RST, 8'h05);
		`CHK(user_fpga_reset, 1'b1)
		rd(bcc_pkg::ADDR_FPGA_RST, 8'h05);
		wr(bcc_pkg::ADDR_FPGA_RST, 8'h00);
		`CHK(user_fpga_reset, 1'b0)
		`CHK(main_bus_disabled, 1'b0)
		wr(bcc_pkg::ADDR_BUS_DIS, 8'($urandom()));
		wr(bcc_pkg::ADDR_BUS_DIS, 8'h00);
		`CHK(main_bus_disabled, 1'b1)
		d = 8'($urandom());
		temp_level = d;
		wr(bcc_pkg::ADDR_TEMP_A, 8'h99);
		rd(bcc_pkg::ADDR_TEMP_A, d);
		rd(bcc_pkg::ADDR_TEMP_B, ~d);
		rd(bcc_pkg::ADDR_SERIAL, sn);
		rd(bcc_pkg::ADDR_KIND, kd);
		wr(16'hdf99, 8'h3c);
		rd(16'hdf99, 8'h00);
		// second reset in mid-run
		@(negedge sys_clk);
		rst = 1'b1;
		@(negedge sys_clk);
		`CHK(main_bus_disabled, 1'b0)
		`CHK(div_o[1], 8'h01)
		rst = 1'b0;
		step_v = 2'b00;
		rd(bcc_pkg::ADDR_SRC_SEL, 8'h00);
		check_nets(3'b000);
		repeat (2) @(negedge sys_clk);
		report_and_stop();
	end
endmodule // board_clock_config_registers_tb
